// ---- input_clock_alarm_status.sv ----
// register bank for input clock alarms, band select and sticky flags
`timescale 1ns/1ps
module input_clock_alarm_status (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // host register port behind the serial interface
    input  wire clkmon_pkg::reg_req_t req,
    output logic [7:0]               reg_rdata_q,
    // live detector status, asynchronous
    input  wire clkmon_pkg::live_t   live_in,
    // interrupt control from the host's own configuration
    input  wire logic                int_pin_en,
    input  wire logic [4:0]          missing_mask,
    input  wire logic [4:0]          offset_mask,
    output logic                     irq_q,
    // bands for the offset monitor of inputs 3 and 4
    output clkmon_pkg::band_t        input3_band_q,
    output clkmon_pkg::band_t        input4_band_q
);

    typedef struct packed {
        clkmon_pkg::live_t s1;
        clkmon_pkg::live_t s2;
        clkmon_pkg::live_t s3;
        clkmon_pkg::live_t live;
        logic [2:0]        input3_band_select;
        logic [2:0]        input4_band_select;
        logic [4:0]        missing_flag;
        logic [4:0]        offset_flag;    // bit 0: unlock, bit k: input k
        logic [7:0]        rdata;
        logic              irq;
        clkmon_pkg::band_t band3;
        clkmon_pkg::band_t band4;
    } state_t;

    state_t q;
    state_t d;
    logic [3:0] active_vec;
    logic [4:0] missing_vec;
    logic [4:0] offset_vec;
    logic [4:0] miss_clr;
    logic [4:0] offs_clr;
    logic [14:0] agree;

    function automatic clkmon_pkg::band_t band_of(input logic [2:0] code);
        band_of = '0;
        if (code < clkmon_pkg::BAND_COUNT) begin
            band_of.low_mhz  = clkmon_pkg::BAND_LOW_MHZ[code];
            band_of.high_mhz = clkmon_pkg::BAND_HIGH_MHZ[code];
            band_of.valid    = 1'b1;
        end
    endfunction : band_of

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    always_comb begin
        d = q;
        // stage 1 is read only by stage 2
        d.s1 = live_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a bit moves only once stages 2 and 3 agree
        agree = ~(q.s2 ^ q.s3);
        d.live = clkmon_pkg::live_t'((agree & q.s3) | (~agree & q.live));

        active_vec  = q.live.selected & ~q.live.missing_live[4:1];
        missing_vec = q.live.missing_live;
        offset_vec  = {q.live.offset_live, q.live.pll_unlocked_live};

        miss_clr = '0;
        offs_clr = '0;
        if (req.wr && hit(req.addr, clkmon_pkg::MISS_FLG_ADDR)) begin
            miss_clr = ~req.wdata[4:0];
        end
        if (req.wr && hit(req.addr, clkmon_pkg::OFFS_FLG_ADDR)) begin
            offs_clr = ~req.wdata[clkmon_pkg::OFFS_FLG_LSB +: 5];
        end
        // an alarm in the clearing cycle still sets the flag
        d.missing_flag = (q.missing_flag & ~miss_clr) | missing_vec;
        d.offset_flag  = (q.offset_flag & ~offs_clr) | offset_vec;

        // interrupt follows the registered flags, one cycle behind
        d.irq = int_pin_en &&
                (|(q.missing_flag & ~missing_mask) ||
                 |(q.offset_flag & ~offset_mask));

        // only the band select takes plain writes; status is read-only
        if (req.wr && hit(req.addr, clkmon_pkg::RATE_SEL_ADDR)) begin
            d.input3_band_select = req.wdata[clkmon_pkg::IN3_BAND_LSB +: 3];
            d.input4_band_select = req.wdata[clkmon_pkg::IN4_BAND_LSB +: 3];
        end
        d.band3 = band_of(q.input3_band_select);
        d.band4 = band_of(q.input4_band_select);

        if (req.rd) begin
            d.rdata = '0;
            case (req.addr)
                clkmon_pkg::RATE_SEL_ADDR: begin
                    d.rdata[clkmon_pkg::IN3_BAND_LSB +: 3] = q.input3_band_select;
                    d.rdata[clkmon_pkg::IN4_BAND_LSB +: 3] = q.input4_band_select;
                end
                clkmon_pkg::ACTIVE_ADDR: begin
                    d.rdata[3:0] = active_vec;
                end
                clkmon_pkg::MISSING_ADDR: begin
                    d.rdata[4:0] = missing_vec;
                end
                clkmon_pkg::OFFSET_ADDR: begin
                    d.rdata[4:0] = offset_vec;
                    d.rdata[clkmon_pkg::HOLD_VALID_BIT] =
                        q.live.hold_history_valid;
                end
                clkmon_pkg::MISS_FLG_ADDR: begin
                    d.rdata[4:0] = q.missing_flag;
                end
                clkmon_pkg::OFFS_FLG_ADDR: begin
                    d.rdata[clkmon_pkg::OFFS_FLG_LSB +: 5] = q.offset_flag;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.input3_band_select <= clkmon_pkg::BAND_RESET;
            q.input4_band_select <= clkmon_pkg::BAND_RESET;
            q.rdata <= clkmon_pkg::RDATA_RESET;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_q   = q.rdata;
    assign irq_q         = q.irq;
    assign input3_band_q = q.band3;
    assign input4_band_q = q.band4;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    rate_write_a: assert property (
        req.wr && req.addr == clkmon_pkg::RATE_SEL_ADDR |=>
        q.input4_band_select == $past(req.wdata[5:3]) &&
        q.input3_band_select == $past(req.wdata[2:0]))
        else $error("band select not stored");
    band_map_a: assert property (
        q.input3_band_select == 3'h0 |=> input3_band_q.valid &&
        input3_band_q.low_mhz == 10'h00a && input3_band_q.high_mhz == 10'h01b)
        else $error("band code 0 mapped wrong");
    band_reserved_a: assert property (
        q.input4_band_select >= clkmon_pkg::BAND_COUNT |=>
        !input4_band_q.valid)
        else $error("reserved band code accepted");
    active_read_a: assert property (
        req.rd && req.addr == clkmon_pkg::ACTIVE_ADDR |=>
        reg_rdata_q == {4'h0, $past(q.live.selected &
                                    ~q.live.missing_live[4:1])})
        else $error("active indicator wrong");
    missing_read_a: assert property (
        req.rd && req.addr == clkmon_pkg::MISSING_ADDR |=>
        reg_rdata_q == {3'h0, $past(q.live.missing_live)})
        else $error("missing-signal status wrong");
    offset_read_a: assert property (
        req.rd && req.addr == clkmon_pkg::OFFSET_ADDR |=>
        reg_rdata_q[7] == 1'b0 && reg_rdata_q[5] == 1'b0 &&
        reg_rdata_q[6] == $past(q.live.hold_history_valid) &&
        reg_rdata_q[0] == $past(q.live.pll_unlocked_live))
        else $error("offset status wrong");
    ro_write_a: assert property (
        req.wr && req.addr == clkmon_pkg::OFFSET_ADDR |=>
        $stable(q.input3_band_select) && $stable(q.input4_band_select))
        else $error("write to status changed state");
    sticky_hold_a: assert property (
        !(req.wr && req.addr == clkmon_pkg::MISS_FLG_ADDR) |=>
        (q.missing_flag & $past(q.missing_flag)) == $past(q.missing_flag))
        else $error("sticky flag dropped");
    set_wins_a: assert property (
        1'b1 |=> (q.offset_flag & $past(offset_vec)) == $past(offset_vec))
        else $error("alarm lost while clearing");
    irq_gate_a: assert property (
        !int_pin_en |=> !irq_q)
        else $error("interrupt while pin disabled");
    irq_raise_a: assert property (
        int_pin_en && |(q.missing_flag & ~missing_mask) |=> irq_q)
        else $error("unmasked flag gave no interrupt");
    offset_bits_a: assert property (
        req.rd && req.addr == clkmon_pkg::OFFSET_ADDR |=>
        reg_rdata_q[4:1] == $past(q.live.offset_live))
        else $error("frequency offset status wrong");
    // six samples: the oldest may reach back to the reset-cleared stages
    sync_lag_a: assert property (
        $stable(live_in) [*5] |-> q.live == $past(live_in))
        else $error("synchronised status wrong");

    clear_cover: cover property (
        req.wr && req.addr == clkmon_pkg::MISS_FLG_ADDR && |q.missing_flag);
    irq_cover: cover property (!irq_q ##1 irq_q);
    active_cover: cover property (
        req.rd && req.addr == clkmon_pkg::ACTIVE_ADDR ##1 |reg_rdata_q);
    reserved_cover: cover property (
        req.wr && req.addr == clkmon_pkg::RATE_SEL_ADDR &&
        req.wdata[2:0] > 3'h5);
    set_clear_cover: cover property (
        req.wr && req.addr == clkmon_pkg::MISS_FLG_ADDR && |missing_vec);
endmodule : input_clock_alarm_status

// ---- clkmon_pkg.sv ----
// register map, field layout and carrier types for the input clock monitor
package clkmon_pkg;
    // register offsets
    localparam logic [7:0] RATE_SEL_ADDR  = 8'h38;
    localparam logic [7:0] ACTIVE_ADDR    = 8'h80;
    localparam logic [7:0] MISSING_ADDR   = 8'h81;
    localparam logic [7:0] OFFSET_ADDR    = 8'h82;
    localparam logic [7:0] MISS_FLG_ADDR  = 8'h83;
    localparam logic [7:0] OFFS_FLG_ADDR  = 8'h84;
    // field positions and reset values
    localparam int         IN3_BAND_LSB   = 0;
    localparam int         IN4_BAND_LSB   = 3;
    localparam int         HOLD_VALID_BIT = 6;
    localparam int         OFFS_FLG_LSB   = 1;
    localparam logic [2:0] BAND_RESET     = 3'h0;
    localparam logic [7:0] RDATA_RESET    = 8'h00;
    // frequency bands, codes 0..5; codes 6 and 7 are reserved
    localparam logic [2:0] BAND_COUNT     = 3'h6;
    localparam logic [9:0] BAND_LOW_MHZ  [6] = '{10'h00a, 10'h019, 10'h032,
                                                  10'h05f, 10'h0be, 10'h177};
    localparam logic [9:0] BAND_HIGH_MHZ [6] = '{10'h01b, 10'h036, 10'h069,
                                                  10'h0d7, 10'h1b3, 10'h2c6};

    // live status from the detectors, outside this clock domain
    typedef struct packed {
        logic       hold_history_valid;
        logic       pll_unlocked_live;
        logic [3:0] offset_live;    // bit k-1: ref input k
        logic [4:0] missing_live;   // bit 0: xtal ref, bit k: ref input k
        logic [3:0] selected;       // one-hot, bit k-1: ref input k
    } live_t;

    // host register access, one request a cycle
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    // expected band handed to the frequency offset monitor
    typedef struct packed {
        logic [9:0] low_mhz;
        logic [9:0] high_mhz;
        logic       valid;
    } band_t;
endpackage : clkmon_pkg

// ---- detector_model.sv ----
// detector model: live alarm levels reaching the bank off the clock grid
`timescale 1ns/1ps
module detector_model (
    // wanted alarm state from the bench
    input  wire clkmon_pkg::live_t want,
    // asynchronous levels into the bank
    output wire clkmon_pkg::live_t live_in
);
    // skewed so that changes land between clock edges, like a real detector;
    // the continuous path settles 3 ns in, while reset still holds the bank, so no stage loads an unknown
    assign #3 live_in = want;
endmodule : detector_model

// ---- input_clock_alarm_status_test.sv ----
// self-checking bench for the input clock alarm register bank
`timescale 1ns/1ps
module input_clock_alarm_status_test;
    logic                 sys_clk;
    logic                 rst;
    clkmon_pkg::reg_req_t req;
    logic [7:0]           reg_rdata_q;
    clkmon_pkg::live_t    want;
    clkmon_pkg::live_t    live_in;
    logic                 int_pin_en;
    logic [4:0]           missing_mask;
    logic [4:0]           offset_mask;
    logic                 irq_q;
    clkmon_pkg::band_t    input3_band_q;
    clkmon_pkg::band_t    input4_band_q;
    int                   mismatches;
    int                   check_count;
    localparam int        LO [6] = '{10, 25, 50, 95, 190, 375};
    localparam int        HI [6] = '{27, 54, 105, 215, 435, 710};
    localparam logic [14:0] PATS [4] = '{15'h0001, 15'h0084, 15'h7418,
                                          15'h0bd2};

    detector_model det (.want(want), .live_in(live_in));
    input_clock_alarm_status dut (.sys_clk(sys_clk), .rst(rst), .req(req),
        .reg_rdata_q(reg_rdata_q), .live_in(live_in),
        .int_pin_en(int_pin_en), .missing_mask(missing_mask),
        .offset_mask(offset_mask), .irq_q(irq_q),
        .input3_band_q(input3_band_q), .input4_band_q(input4_band_q));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [20:0] band(int c);
        if (c > 5) return 21'h0;
        return {10'(LO[c]), 10'(HI[c]), 1'b1};
    endfunction : band

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic check(string name, logic [20:0] seen, logic [20:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // strobes are lowered and an edge passes, so calls may follow at once
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge sys_clk) #1;
        req.wr = 1'b0;
        @(posedge sys_clk) #1;
    endtask : wr

    task automatic rc(logic [7:0] a, logic [7:0] exp, string name);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk) #1;
        req.rd = 1'b0;
        check(name, reg_rdata_q, exp);
        @(posedge sys_clk) #1;
    endtask : rc

    task automatic live_chk(clkmon_pkg::live_t w);
        rc(8'h80, {4'h0, w.selected & ~w.missing_live[4:1]}, "act");
        rc(8'h81, {3'h0, w.missing_live}, "miss");
        rc(8'h82, {1'b0, w.hold_history_valid, 1'b0, w.offset_live,
                   w.pll_unlocked_live}, "offs");
    endtask : live_chk

    task automatic wait_irq(logic exp);
        int n;
        n = 0;
        while (irq_q !== exp && n < 10) begin
            @(posedge sys_clk) #1;
            n++;
        end
        check("irq", irq_q, exp);
        if (irq_q !== exp) conclude();
    endtask : wait_irq

    initial begin
        #100000;
        mismatches++;
        conclude();
    end

    initial begin
        req = '0;
        want = '0;
        int_pin_en = 1'b0;
        missing_mask = 5'h00;
        offset_mask = 5'h00;
        mismatches = 0;
        check_count = 0;
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        @(posedge sys_clk) #1;
        check("band3 reset", input3_band_q, band(0));
        rc(clkmon_pkg::RATE_SEL_ADDR, 8'h00, "rate reset");
        for (int c = 0; c < 8; c++) begin
            wr(clkmon_pkg::RATE_SEL_ADDR, {2'b11, 3'(7 - c), 3'(c)});
            check("band3", input3_band_q, band(c));
            check("band4", input4_band_q, band(7 - c));
            rc(8'h38, {2'b00, 3'(7 - c), 3'(c)}, "rate");
        end
        // the synchroniser needs 4 edges; 8 leaves margin
        for (int i = 0; i < 4; i++) begin
            want = PATS[i];
            repeat (8) @(posedge sys_clk) #1;
            live_chk(PATS[i]);
        end
        for (int a = 8'h80; a < 8'h83; a++) wr(8'(a), 8'hff);
        live_chk(PATS[3]);
        rc(8'h55, 8'h00, "unmapped");
        want = '0;
        int_pin_en = 1'b1;
        wait_irq(1'b1);
        rc(8'h83, 8'h1d, "miss flags");
        rc(8'h84, 8'h3e, "offs flags");
        missing_mask = 5'h1f;
        offset_mask = 5'h1f;
        wait_irq(1'b0);
        missing_mask = 5'h00;
        offset_mask = 5'h00;
        wr(8'h83, 8'h1c);
        rc(8'h83, 8'h1c, "partial clear");
        wr(8'h83, 8'h00);
        wr(8'h84, 8'h00);
        wait_irq(1'b0);
        int_pin_en = 1'b0;
        want.missing_live = 5'h01;
        repeat (8) @(posedge sys_clk) #1;
        check("irq disabled", irq_q, 1'b0);
        int_pin_en = 1'b1;
        wait_irq(1'b1);
        // clear while the alarm still stands: the flag must survive
        wr(8'h83, 8'h00);
        rc(8'h83, 8'h01, "set wins");
        missing_mask = 5'h01;
        wait_irq(1'b0);
        conclude();
    end
endmodule : input_clock_alarm_status_test
